//--- issr_pkg.sv
// Purpose: shared constants for the inertial sensor serial slave port
// Assumes: system clock of 20 MHz
// Notes: byte map is 128 bytes; word registers sit at even byte addresses
package issr_pkg;

   // ----------------------------------------------------------------
   // Clock and sample timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20000000;           // System clock rate
   localparam int SAMPLE_RATE_MILLI = 819200;  // Default rate, 819.2 SPS in milli-SPS
   // Sample period in cycles, rounded down (shortest time)
   localparam int SAMPLE_CYCLES = int'((64'(CLK_HZ) * 64'd1000) / 64'(SAMPLE_RATE_MILLI));
   localparam int SAMPLE_CNT_W = 16;           // Counter width for the sample period

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 16;             // Bits per serial frame
   localparam int BIT_CNT_W = 5;               // Bit counter width
   localparam int ADDR_W = 7;                  // Byte address width
   localparam int BYTE_COUNT = 128;            // Bytes in the map
   localparam int RW_BIT = 15;                 // Direction flag position
   localparam int ADDR_MSB = 14;               // Address field top bit
   localparam int ADDR_LSB = 8;                // Address field bottom bit
   localparam int DATA_MSB = 7;                // Write byte top bit
   localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h0f; // Index of final bit

   // ----------------------------------------------------------------
   // Output word addresses (low byte)
   // ----------------------------------------------------------------
   localparam int NUM_OUT = 11;                // Output words refreshed per sample
   localparam logic [ADDR_W-1:0] OUT_BASE = 7'h02; // First output word
   localparam logic [15:0] SAMPLE_RST = 16'h0000;  // Sample counter reset value
   localparam logic [15:0] DATA_READY_PULSE = 16'h0001; // Pulse width in cycles

   // ----------------------------------------------------------------
   // Wishbone register map
   // ----------------------------------------------------------------
   localparam logic [3:0] WB_STATUS = 4'h0;    // Sticky event bits, write one to clear
   localparam logic [3:0] WB_MASK = 4'h4;      // Interrupt mask
   localparam logic [3:0] WB_CTRL = 4'h8;      // Control: bit0 sampling enable
   localparam logic [3:0] WB_COUNT = 4'hc;     // Sample counter, read only
   localparam logic [2:0] EV_SAMPLE = 3'h0;    // Status: sample done
   localparam logic [2:0] EV_READ = 3'h1;      // Status: read command taken
   localparam logic [2:0] EV_WRITE = 3'h2;     // Status: write frame taken
   localparam int NUM_EV = 3;                  // Number of events
   localparam logic [31:0] CTRL_RST = 32'h0000_0001; // Sampling on at reset

   // ----------------------------------------------------------------
   // Serial engine states
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ISSR_IDLE = 2'b01,   // Chip select high
      ISSR_SHIFT = 2'b10   // Inside a frame
   } issr_state_type;

endpackage

//--- issr_props.sv
// Purpose: concurrent checks on the pins of the serial slave port
// Assumes: SCLK far slower than CLK_SYS
// Notes: bound to issr_top below the module
`timescale 1ns/10ps
module issr_props
   import issr_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic SDO,
   input wire logic SAMPLE_READY_PULSE_PIN,
   input wire logic IRQ,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O
);
   // ----------------------------------------------------------------
   // Helper counters
   // ----------------------------------------------------------------
   logic [15:0] gap_q; // Cycles since the last data-ready pulse
   logic seen_q; // A pulse has come since reset
   logic [3:0] fall_age_q; // Cycles since SCLK fell, saturating

   // Gap counter; first pulse after reset is not judged
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         gap_q <= 16'h0000;
         seen_q <= 1'b0;
      end
      else if (SAMPLE_READY_PULSE_PIN)
      begin
         gap_q <= 16'h0001;
         seen_q <= 1'b1;
      end
      else if (gap_q != 16'hffff)
         gap_q <= gap_q + 16'h0001;
   end

   // Age of the last clock fall; raw pin, so it leads the design's view
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET || $fell(SCLK))
         fall_age_q <= 4'h0;
      else if (fall_age_q != 4'hf)
         fall_age_q <= fall_age_q + 4'h1;
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   AST_PULSE_ONE: assert property (SAMPLE_READY_PULSE_PIN |=> !SAMPLE_READY_PULSE_PIN)
      else $error("data-ready pulse wider than one cycle");
   AST_PULSE_GAP: assert property ((SAMPLE_READY_PULSE_PIN && seen_q) |-> gap_q >= 16'(SAMPLE_CYCLES))
      else $error("data-ready pulses closer than one sample period");
   AST_SDO_FALL: assert property ($changed(SDO) |-> fall_age_q <= 4'h6)
      else $error("serial output changed away from a clock fall");
   AST_SDO_CS: assert property ((CS_N && $past(CS_N)) |-> $stable(SDO))
      else $error("serial output moved while deselected");
   AST_ACK_NEXT: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
      else $error("bus request not answered in one cycle");
   AST_ACK_DROP: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("bus acknowledge held beyond one cycle");
   AST_DAT_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
      else $error("bus read data not zero outside acknowledge");
   AST_RESET_QUIET: assert property ($fell(RESET) |-> !(SAMPLE_READY_PULSE_PIN || IRQ || WB_ACK_O))
      else $error("outputs active at the first edge after reset");
endmodule

bind issr_top issr_props issr_props_inst (.CLK_SYS(CLK_SYS), .RESET(RESET), .SCLK(SCLK),
   .CS_N(CS_N), .SDO(SDO), .SAMPLE_READY_PULSE_PIN(SAMPLE_READY_PULSE_PIN), .IRQ(IRQ),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O));

//--- issr_spi_master.sv
// Purpose: behavioural master processor on the far side of the serial link
// Assumes: 400 ns serial clock period
// Notes: clock runs only inside frames; data line toggles when released
`timescale 1ns/10ps
module issr_spi_master
(
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo
);
   // Idle link: clock high, deselected
   initial
   begin
      sclk = 1'b1;
      cs_n = 1'b1;
      sdi = 1'b0;
   end

   // One frame of nb bits, MSB first; keep leaves the device selected
   task automatic frame(input logic [15:0] tx, input int nb, input logic keep,
      output logic [15:0] rx);
      rx = 16'h0000;
      #13;
      cs_n = 1'b0;
      #200;
      for (int i = 15; i > 15 - nb; i--)
      begin
         // 400 ns period keeps the run short; the port needs four system
         // cycles per half, so slower legal clocks are easier still.
         // No burst read and no low-power mode here, so one speed serves.
         sclk = 1'b0;
         sdi = tx[i];
         #200;
         sclk = 1'b1;
         rx[i] = sdo;
         #200;
      end
      // Released line must not look like held data
      if (!keep)
      begin
         cs_n = 1'b1;
         sdi = ~sdi;
         #400;
      end
   endtask
endmodule

//--- issr_sync.sv
// Purpose: two-flop synchroniser for pins entering the system clock
// Assumes: input is asynchronous to CLK_SYS
// Notes: first stage feeds only the second
`timescale 1ns/10ps
module issr_sync
   import issr_pkg::*;
#(
   parameter logic INIT = 1'b1
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);

   logic meta_q; // First stage, read only by dout

   // ----------------------------------------------------------------
   // Two stages
   // ----------------------------------------------------------------
   // Both stages reset to the idle level of the pin
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_q <= INIT;
         dout <= INIT;
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end

endmodule

//--- issr_top.sv
// Purpose: serial slave port of an autonomous inertial sensor
// Assumes: SCLK far slower than CLK_SYS (at least four system cycles per half)
// Notes: Wishbone classic slave for status, mask, control and count
`timescale 1ns/10ps
module issr_top
   import issr_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic SDI,
   output logic SDO,
   output logic SAMPLE_READY_PULSE_PIN,
   output logic IRQ,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic sclk_s; // Synchronised serial clock
   logic cs_n_s; // Synchronised chip select
   logic sdi_s;  // Synchronised serial input

   issr_sync #(.INIT(1'b1)) u_sync_sclk (.clk(CLK_SYS), .rst(RESET), .din(SCLK), .dout(sclk_s));
   issr_sync #(.INIT(1'b1)) u_sync_cs (.clk(CLK_SYS), .rst(RESET), .din(CS_N), .dout(cs_n_s));
   issr_sync #(.INIT(1'b0)) u_sync_sdi (.clk(CLK_SYS), .rst(RESET), .din(SDI), .dout(sdi_s));

   // ----------------------------------------------------------------
   // Edge detection on the serial clock
   // ----------------------------------------------------------------
   logic sclk_prev_q; // Last synchronised clock level
   logic sclk_rise;   // Rising edge seen
   logic sclk_fall;   // Falling edge seen

   // Idle high in mode 3, so reset to one to avoid a false edge
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         sclk_prev_q <= 1'b1;
      else
         sclk_prev_q <= sclk_s;
   end

   assign sclk_rise = sclk_s & ~sclk_prev_q;
   assign sclk_fall = ~sclk_s & sclk_prev_q;

   // ----------------------------------------------------------------
   // Byte map and sample generation
   // ----------------------------------------------------------------
   logic [7:0] mem_q [BYTE_COUNT];        // Register bytes
   logic [SAMPLE_CNT_W-1:0] tick_cnt_q;   // Sample period counter
   logic [15:0] sample_num_q;             // Running sample count, seeds output data
   logic sample_done;                     // One-cycle sample end
   logic sample_en;                       // Sampling enable from control
   logic wr_fire;                         // Serial write frame finished
   logic [ADDR_W-1:0] wr_addr;            // Serial write byte address
   logic [7:0] wr_byte;                   // Serial write byte

   assign sample_done = sample_en &&
      (tick_cnt_q == SAMPLE_CNT_W'(SAMPLE_CYCLES - 1));

   // Period counter runs while sampling is enabled, which it is from reset; no command needed to start
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         tick_cnt_q <= '0;
      else if (sample_done || !sample_en)
         tick_cnt_q <= '0;
      else
         tick_cnt_q <= tick_cnt_q + 1'b1;
   end

   // Sample counter, visible over the bus
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         sample_num_q <= SAMPLE_RST;
      else if (sample_done)
         sample_num_q <= sample_num_q + 1'b1;
   end

   // Output words are refreshed each sample; the rest hold written bytes.
   // Output words carry the sample count plus their index as stand-in data.
   genvar gi;
   generate
      for (gi = 0; gi < BYTE_COUNT; gi++)
      begin : g_mem
         localparam int WORD = gi / 2;
         localparam bit IS_OUT = (gi >= int'(OUT_BASE)) &&
            (gi < int'(OUT_BASE) + 2 * NUM_OUT);
         always_ff @(posedge CLK_SYS)
         begin
            if (RESET)
               mem_q[gi] <= 8'h00;
            else if (IS_OUT && sample_done)
            begin
               // Refresh at sample end, on the same edge that raises the ready pulse
               if (gi % 2 == 0)
                  mem_q[gi] <= 8'(sample_num_q + 16'(WORD));
               else
                  mem_q[gi] <= 8'((sample_num_q + 16'(WORD)) >> 8);
            end
            else if (wr_fire && wr_addr == ADDR_W'(gi))
               mem_q[gi] <= wr_byte;
         end
      end
   endgenerate

   // Ready pulse rises on the same edge as the refresh
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         SAMPLE_READY_PULSE_PIN <= 1'b0;
      else
         SAMPLE_READY_PULSE_PIN <= sample_done;
   end

   // ----------------------------------------------------------------
   // Serial frame engine
   // ----------------------------------------------------------------
   issr_state_type state_q;              // Engine state
   logic [BIT_CNT_W-1:0] bit_cnt_q;      // Bits taken this frame
   logic [FRAME_BITS-1:0] rx_q;          // Incoming frame
   logic [FRAME_BITS-1:0] tx_q;          // Outgoing word
   logic [FRAME_BITS-1:0] rx_full;       // Frame with last bit merged
   logic frame_end;                      // Sixteenth rising edge
   logic rd_fire;                        // Read command finished
   logic [ADDR_W-1:0] rd_base;           // Even byte address of read word

   assign rx_full = {rx_q[FRAME_BITS-2:0], sdi_s};
   assign frame_end = (state_q == ISSR_SHIFT) && sclk_rise && (bit_cnt_q == LAST_BIT);
   assign wr_fire = frame_end && rx_full[RW_BIT];
   assign rd_fire = frame_end && !rx_full[RW_BIT];
   assign wr_addr = rx_full[ADDR_MSB:ADDR_LSB];
   assign wr_byte = rx_full[DATA_MSB:0];
   // Either byte address reaches the same word
   assign rd_base = {rx_full[ADDR_MSB:ADDR_LSB+1], 1'b0};

   // Frame state follows chip select only
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         state_q <= ISSR_IDLE;
      else
      begin
         case (state_q)
            ISSR_IDLE:
               if (!cs_n_s)
                  state_q <= ISSR_SHIFT;
            ISSR_SHIFT:
               if (cs_n_s)
                  state_q <= ISSR_IDLE;
            default:
               state_q <= ISSR_IDLE;
         endcase
      end
   end

   // Bit counter; cleared while deselected, wraps for back-to-back frames
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         bit_cnt_q <= '0;
      else if (state_q != ISSR_SHIFT || cs_n_s)
         bit_cnt_q <= '0;
      else if (frame_end)
         bit_cnt_q <= '0;
      else if (sclk_rise)
         bit_cnt_q <= bit_cnt_q + 1'b1;
   end

   // Input shift on rising edges, MSB first
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         rx_q <= '0;
      else if (state_q == ISSR_SHIFT && !cs_n_s && sclk_rise)
         rx_q <= rx_full;
   end

   // Output word: loaded at read command end, shifted on falling edges.
   // The load lands before the next falling edge, so bit 15 leads the
   // next frame while that frame carries the next command.
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         tx_q <= '0;
      else if (rd_fire)
         tx_q <= {mem_q[rd_base + 1'b1], mem_q[rd_base]};
      else if (wr_fire)
         tx_q <= '0;
      else if (state_q == ISSR_SHIFT && !cs_n_s && sclk_fall && bit_cnt_q != '0)
         tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
   end

   // First falling edge of a frame presents bit 15; later ones advance
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         SDO <= 1'b0;
      else if (state_q == ISSR_SHIFT && !cs_n_s && sclk_fall)
      begin
         if (bit_cnt_q == '0)
            SDO <= tx_q[FRAME_BITS-1];
         else
            SDO <= tx_q[FRAME_BITS-2];
      end
   end

   // ----------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------
   logic [NUM_EV-1:0] status_q;  // Sticky events
   logic [NUM_EV-1:0] mask_q;    // Interrupt enables
   logic [31:0] ctrl_q;          // Control word
   logic [NUM_EV-1:0] ev_set;    // Events this cycle
   logic wb_req;                 // New bus request
   logic wb_wr;                  // Write taken this cycle

   assign sample_en = ctrl_q[0];
   assign ev_set = {wr_fire, rd_fire, sample_done};
   assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign wb_wr = wb_req && WB_WE_I && WB_SEL_I[0];

   // Set wins over a simultaneous write-one-to-clear
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         status_q <= '0;
      else if (wb_wr && WB_ADR_I == WB_STATUS)
         status_q <= (status_q & ~WB_DAT_I[NUM_EV-1:0]) | ev_set;
      else
         status_q <= status_q | ev_set;
   end

   // Mask and control registers
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         mask_q <= '0;
         ctrl_q <= CTRL_RST;
      end
      else if (wb_wr && WB_ADR_I == WB_MASK)
         mask_q <= WB_DAT_I[NUM_EV-1:0];
      else if (wb_wr && WB_ADR_I == WB_CTRL)
         ctrl_q <= {31'h0000_0000, WB_DAT_I[0]};
   end

   // Level interrupt, registered
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         IRQ <= 1'b0;
      else
         IRQ <= |(status_q & mask_q);
   end

   // ----------------------------------------------------------------
   // Wishbone slave: one-cycle ack, unmapped reads return zero
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= '0;
      end
      else
      begin
         WB_ACK_O <= wb_req;
         if (!wb_req)
            WB_DAT_O <= '0;
         else if (WB_ADR_I == WB_STATUS)
            WB_DAT_O <= 32'(status_q);
         else if (WB_ADR_I == WB_MASK)
            WB_DAT_O <= 32'(mask_q);
         else if (WB_ADR_I == WB_CTRL)
            WB_DAT_O <= ctrl_q;
         else if (WB_ADR_I == WB_COUNT)
            WB_DAT_O <= 32'(sample_num_q);
         else
            WB_DAT_O <= '0;
      end
   end

endmodule

//--- tb_top.sv
// Purpose: self-checking bench for the inertial sensor serial slave port
// Assumes: 20 MHz system clock; sampling runs at full period
// Notes: about 50000 cycles, mostly two sample periods
`timescale 1ns/10ps
module tb_top
   import issr_pkg::*;
;
   logic clk_sys = 1'b0; // System clock
   logic reset = 1'b1; // Held for three cycles
   logic sclk, cs_n, sdi, sdo; // Serial link
   logic pulse, irq; // Data-ready and interrupt
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0; // Bus request
   logic [3:0] wb_adr = 4'h0, wb_sel = 4'hf; // Bus address and lanes
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd; // Bus data
   logic wb_ack; // Bus answer
   logic [15:0] rx; // Word returned by a frame
   int bad_count = 0, n_checks = 0, cycles = 0;

   issr_top issr_top_inst (.CLK_SYS(clk_sys), .RESET(reset), .SCLK(sclk), .CS_N(cs_n),
      .SDI(sdi), .SDO(sdo), .SAMPLE_READY_PULSE_PIN(pulse), .IRQ(irq), .WB_CYC_I(wb_cyc),
      .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel),
      .WB_DAT_I(wb_dat_i), .WB_DAT_O(wb_dat_o), .WB_ACK_O(wb_ack));
   issr_spi_master issr_spi_master_inst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

   always #25 clk_sys = ~clk_sys;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task final_report;
      $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Classic single cycle; no fixed latency assumed, a stuck slave is bounded
   task wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      int n;
      @(posedge clk_sys);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat_i <= dat;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      chk("bus ack", 32'h1, {31'h0, wb_ack});
   endtask

   // Count edges until data-ready; returns with the pulse just seen
   task wait_pulse(output int n);
      n = 0;
      while (pulse !== 1'b1 && n < 30000)
      begin
         @(posedge clk_sys);
         n++;
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task test_rate;
      int n;
      wait_pulse(n);
      chk("first pulse", 32'h1, {31'h0, pulse});
      @(posedge clk_sys);
      chk("pulse width", 32'h0, {31'h0, pulse});
      wait_pulse(n);
      chk("sample period", SAMPLE_CYCLES - 1, n);
      wb_xfer(1'b0, WB_COUNT, 32'h0);
      chk("sample count", 32'h0000_0002, rd);
      wb_xfer(1'b0, WB_STATUS, 32'h0);
      chk("sample event", 32'h0000_0001, rd);
   endtask

   // Registered IRQ follows a status or mask write within two edges
   task test_irq;
      wb_xfer(1'b1, WB_MASK, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk("irq masked", 32'h0, {31'h0, irq});
      wb_xfer(1'b1, WB_MASK, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk("irq raised", 32'h1, {31'h0, irq});
      wb_xfer(1'b1, WB_STATUS, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wb_xfer(1'b0, 4'h2, 32'h0);
      chk("unmapped read", 32'h0, rd);
      wb_xfer(1'b1, WB_CTRL, 32'h0);
      wb_xfer(1'b1, WB_MASK, 32'h6);
   endtask

   // Sampling is stopped, so written bytes stay put
   task test_spi;
      issr_spi_master_inst.frame(16'h84a5, 16, 1'b1, rx);
      issr_spi_master_inst.frame(16'h853c, 16, 1'b1, rx);
      chk("after write", 32'h0, {16'h0, rx});
      issr_spi_master_inst.frame(16'h0400, 16, 1'b1, rx);
      chk("after write", 32'h0, {16'h0, rx});
      issr_spi_master_inst.frame(16'h0500, 16, 1'b1, rx);
      chk("word at 0x04", 32'h3ca5, {16'h0, rx});
      issr_spi_master_inst.frame(16'h0000, 16, 1'b0, rx);
      chk("word at 0x05", 32'h3ca5, {16'h0, rx});
      issr_spi_master_inst.frame(16'h84ff, 7, 1'b0, rx);
      issr_spi_master_inst.frame(16'h0400, 16, 1'b1, rx);
      issr_spi_master_inst.frame(16'h0600, 16, 1'b1, rx);
      chk("after abort", 32'h3ca5, {16'h0, rx});
      // Last refresh came with the second sample: count one plus index three
      issr_spi_master_inst.frame(16'h0000, 16, 1'b0, rx);
      chk("word at 0x06", 32'h0004, {16'h0, rx});
      wb_xfer(1'b0, WB_STATUS, 32'h0);
      chk("link events", 32'h0000_0006, rd);
      chk("link irq", 32'h1, {31'h0, irq});
   endtask

   // ----------------------------------------------------------------
   // Main sequence and hang guard
   // ----------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      test_rate();
      test_irq();
      test_spi();
      final_report();
   end

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         bad_count++;
         $display("Run stopped at cycle limit %0d", cycles);
         final_report();
      end
   end
endmodule
